/* hdl/adcsc_pkg.sv */
/*
   Shared constants for the conversion and serial control block.
   Assumes a 200 MHz system clock and a host-driven serial clock.
*/
package adcsc_pkg;

   // System clock and conversion times
   localparam int CLK_PERIOD_NS    = 5;
   localparam int T_CONV_VOLT_NS   = 9000;
   localparam int T_CONV_TEMP_NS   = 27000;
   // Longest times round down
   localparam int CONV_VOLT_CYCLES = T_CONV_VOLT_NS / CLK_PERIOD_NS;
   localparam int CONV_TEMP_CYCLES = T_CONV_TEMP_NS / CLK_PERIOD_NS;
   localparam int CONV_CNT_W       = 13;

   // Data widths
   localparam int RESULT_W = 10;
   localparam int LIMIT_W  = 8;
   localparam int BYTE_W   = 8;
   localparam int CHAN_W   = 3;
   localparam int BIT_CNT_W = 4;

   // Address register field and codes
   localparam int CHAN_LSB = 0;
   localparam logic [CHAN_W-1:0] CHAN_TEMP = 3'h0;
   localparam logic [CHAN_W-1:0] CHAN_VIN_LAST = 3'h4;
   localparam logic [CHAN_W-1:0] LIMIT_SEL = 3'h7;
   // Limit compared against the top byte of the result
   localparam int CMP_LSB = RESULT_W - LIMIT_W;

   // Values after reset
   localparam logic [CHAN_W-1:0]   ADDR_RST   = 3'h0;
   localparam logic [LIMIT_W-1:0]  LIMIT_RST  = 8'hff;
   localparam logic [RESULT_W-1:0] RESULT_RST = 10'h000;

   typedef enum logic [0:0] {ADCSC_IDLE, ADCSC_CONV} adcsc_state_t;

endpackage

/* hdl/adcsc_link.sv */
/*
   Serial clock side of the port: captures write bytes on rising edges
   and shifts the result out on falling edges.
   Assumes the host holds chip select and read/write select steady
   around serial clock edges; the serial clock may stop between frames.
   Assumes rst_n clears the byte toggle while the serial clock idles.
*/
`timescale 1ns/1ps
module adcsc_link #(
   parameter int RESULT_W = adcsc_pkg::RESULT_W,
   parameter int BYTE_W   = adcsc_pkg::BYTE_W
) (
   input  wire logic                sclk,
   input  wire logic                rst_n,
   input  wire logic                chip_select_n,
   input  wire logic                rd_wr,
   input  wire logic                data_in,
   input  wire logic [RESULT_W-1:0] read_word,
   output logic                     data_out,
   output logic [BYTE_W-1:0]        write_byte,
   output logic                     write_toggle
);

   logic [BYTE_W-1:0]                 shift_in;
   logic [adcsc_pkg::BIT_CNT_W-1:0]   wr_count;
   logic [adcsc_pkg::BIT_CNT_W-1:0]   rd_count;
   logic                              rd_end_n;
   wire                               wr_take;
   wire                               byte_done;
   wire  [BYTE_W-1:0]                 next_shift;
   wire                               next_bit;

   // Only respond while selected
   assign wr_take    = !chip_select_n && !rd_wr;
   assign next_shift = {shift_in[BYTE_W-2:0], data_in};
   assign byte_done  = wr_count == adcsc_pkg::BIT_CNT_W'(BYTE_W - 1);
   assign next_bit   = (rd_count < adcsc_pkg::BIT_CNT_W'(RESULT_W))
                       ? read_word[RESULT_W - 1 - int'(rd_count)] : 1'b0;
   assign rd_end_n   = !chip_select_n && rd_wr;

   // Frame end clears the count; the clock may never tick again
   always_ff @(posedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         wr_count <= '0;
      end else if (wr_take) begin
         wr_count <= byte_done ? '0 : wr_count + 1'b1;
      end
   end

   // Capture input on rising edges
   always_ff @(posedge sclk) begin
      if (wr_take) begin
         shift_in <= next_shift;
      end
   end

   // Whole byte held stable, toggle announces it
   always_ff @(posedge sclk) begin
      if (wr_take && byte_done) begin
         write_byte <= next_shift;
      end
   end

   // Known start value, else the far side never sees a change
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         write_toggle <= 1'b0;
      end else if (wr_take && byte_done) begin
         write_toggle <= !write_toggle;
      end
   end

   // Read count restarts when a read is no longer requested
   always_ff @(negedge sclk or negedge rd_end_n) begin
      if (!rd_end_n) begin
         rd_count <= '0;
      end else if (rd_count != adcsc_pkg::BIT_CNT_W'(RESULT_W)) begin
         rd_count <= rd_count + 1'b1;
      end
   end

   // Shift out on falling edges, MSB first
   always_ff @(negedge sclk or negedge rd_end_n) begin
      if (!rd_end_n) begin
         data_out <= 1'b0;
      end else begin
         data_out <= next_bit;
      end
   end

endmodule

/* hdl/adcsc_top.sv */
/*
   Conversion sequencer, overtemperature compare and serial port pin
   control of a four-channel converter with a temperature channel.
   Assumes the analog core presents its code on adc_code by the end of
   the conversion window, and that the host does not read during one.
*/
`timescale 1ns/1ps
module adcsc_top #(
   parameter int CONV_VOLT_CYCLES = adcsc_pkg::CONV_VOLT_CYCLES,
   parameter int CONV_TEMP_CYCLES = adcsc_pkg::CONV_TEMP_CYCLES,
   parameter int RESULT_W         = adcsc_pkg::RESULT_W
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       convert_start_n,
   input  wire logic [RESULT_W-1:0]        adc_code,
   input  wire logic                       sclk,
   input  wire logic                       chip_select_n,
   input  wire logic                       rd_wr,
   input  wire logic                       data_in,
   output logic                            data_out,
   output logic                            data_out_en,
   output logic                            busy,
   output logic                            hold,
   output logic                            power_down,
   output logic                            overtemp_flag_n,
   output logic [adcsc_pkg::CHAN_W-1:0]    channel_sel
);

   localparam int NSYNC = 4;

   adcsc_pkg::adcsc_state_t               state;
   adcsc_pkg::adcsc_state_t               next_state;
   logic [adcsc_pkg::CONV_CNT_W-1:0]      conv_count;
   logic [adcsc_pkg::CONV_CNT_W-1:0]      next_count;
   logic [RESULT_W-1:0]                   result;
   logic [adcsc_pkg::LIMIT_W-1:0]         overtemp_limit_reg;
   logic                                  limit_pending;
   logic                                  conv_temp;
   logic [NSYNC-1:0]                      sync_a;
   logic [NSYNC-1:0]                      sync_b;
   logic                                  start_d;
   logic                                  rd_wr_d;
   logic                                  cs_d;
   logic                                  tgl_d;
   logic                                  link_dout;
   logic [adcsc_pkg::BYTE_W-1:0]          link_byte;
   logic                                  link_toggle;

   wire                                   start_s;
   wire                                   cs_s;
   wire                                   rd_wr_s;
   wire                                   tgl_s;
   wire                                   start_fall;
   wire                                   start_rise;
   wire                                   rd_rise;
   wire                                   rd_fall;
   wire                                   cs_rise;
   wire                                   byte_new;
   wire                                   limit_sel;
   wire                                   conv_end;
   wire                                   ot_set;
   wire                                   ot_clr;
   wire  [adcsc_pkg::CONV_CNT_W-1:0]      conv_last;
   wire  [adcsc_pkg::CHAN_W-1:0]          byte_chan;
   wire  [adcsc_pkg::LIMIT_W-1:0]         code_top;
   wire                                   chan_write;
   wire                                   limit_write;
   wire                                   conv_start;
   wire                                   pd_enter;
   wire                                   pd_exit;
   wire                                   out_release;
   wire                                   out_drive;

   // Pin and cross-domain inputs pass two flip-flops
   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         wire raw;
         if (i == 0) begin : g_s
            assign raw = convert_start_n;
         end else if (i == 1) begin : g_c
            assign raw = chip_select_n;
         end else if (i == 2) begin : g_r
            assign raw = rd_wr;
         end else begin : g_t
            assign raw = link_toggle;
         end
         always_ff @(posedge clk) begin
            sync_a[i] <= raw;
            sync_b[i] <= sync_a[i];
         end
      end
   endgenerate

   assign start_s = sync_b[0];
   assign cs_s    = sync_b[1];
   assign rd_wr_s = sync_b[2];
   assign tgl_s   = sync_b[3];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_d <= 1'b1;
         cs_d    <= 1'b1;
         rd_wr_d <= 1'b0;
         tgl_d   <= 1'b0;
      end else begin
         start_d <= start_s;
         cs_d    <= cs_s;
         rd_wr_d <= rd_wr_s;
         tgl_d   <= tgl_s;
      end
   end

   // Edge decode
   // Edge registers reset to idle pin levels, so no false edge after reset
   assign start_fall = start_d && !start_s;
   assign start_rise = !start_d && start_s;
   assign rd_rise    = !rd_wr_d && rd_wr_s && !cs_s;
   assign rd_fall    = rd_wr_d && !rd_wr_s;
   assign cs_rise    = !cs_d && cs_s;
   assign byte_new   = tgl_d != tgl_s;

   // Serial clock domain
   // Toggle cleared by rst_n; the serial clock must idle while it is low
   adcsc_link #(
      .RESULT_W (RESULT_W),
      .BYTE_W   (adcsc_pkg::BYTE_W)
   ) u_link (
      .sclk          (sclk),
      .rst_n         (rst_n),
      .chip_select_n (chip_select_n),
      .rd_wr         (rd_wr),
      .data_in       (data_in),
      .read_word     (result),
      .data_out      (link_dout),
      .write_byte    (link_byte),
      .write_toggle  (link_toggle)
   );

   assign data_out = link_dout;

   // Written byte decode
   assign byte_chan = link_byte[adcsc_pkg::CHAN_LSB +: adcsc_pkg::CHAN_W];
   assign limit_sel = byte_chan == adcsc_pkg::LIMIT_SEL;
   assign chan_write  = byte_new && !limit_pending && !limit_sel
                        && byte_chan <= adcsc_pkg::CHAN_VIN_LAST;
   assign limit_write = byte_new && limit_pending;

   // Address register picks the input to convert
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         channel_sel <= adcsc_pkg::ADDR_RST;
      end else if (chan_write) begin
         channel_sel <= byte_chan;
      end
   end

   // A limit pointer byte makes the next byte in the same frame the limit; frame end cancels it
   always_ff @(posedge clk) begin
      if (!rst_n || cs_rise) begin
         limit_pending <= 1'b0;
      end else if (byte_new) begin
         limit_pending <= !limit_pending && limit_sel;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         overtemp_limit_reg <= adcsc_pkg::LIMIT_RST;
      end else if (limit_write) begin
         overtemp_limit_reg <= link_byte;
      end
   end

   // Conversion length by channel
   assign conv_last = conv_temp
                      ? adcsc_pkg::CONV_CNT_W'(CONV_TEMP_CYCLES - 1)
                      : adcsc_pkg::CONV_CNT_W'(CONV_VOLT_CYCLES - 1);
   assign conv_end  = state == adcsc_pkg::ADCSC_CONV && conv_count == conv_last;

   always_comb begin
      next_state = state;
      next_count = conv_count;
      case (state)
         adcsc_pkg::ADCSC_IDLE: begin
            next_count = '0;
            if (start_fall) begin
               next_state = adcsc_pkg::ADCSC_CONV;
            end
         end
         adcsc_pkg::ADCSC_CONV: begin
            next_count = conv_count + 1'b1;
            if (conv_end) begin
               next_state = adcsc_pkg::ADCSC_IDLE;
               next_count = '0;
            end
         end
         default: begin
            next_state = adcsc_pkg::ADCSC_IDLE;
            next_count = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state      <= adcsc_pkg::ADCSC_IDLE;
         conv_count <= '0;
      end else begin
         state      <= next_state;
         conv_count <= next_count;
      end
   end

   assign conv_start = state == adcsc_pkg::ADCSC_IDLE && start_fall;

   // Channel latched at start; later writes do not stretch this one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_temp <= 1'b0;
      end else if (conv_start) begin
         conv_temp <= channel_sel == adcsc_pkg::CHAN_TEMP;
      end
   end

   // Busy and hold follow the conversion
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy <= 1'b0;
         hold <= 1'b0;
      end else begin
         busy <= next_state == adcsc_pkg::ADCSC_CONV;
         hold <= next_state == adcsc_pkg::ADCSC_CONV;
      end
   end

   // 10-bit code taken at the end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result <= adcsc_pkg::RESULT_RST;
      end else if (conv_end) begin
         result <= adc_code;
      end
   end

   // Low start level at the end powers down; a rising edge wakes
   // Status only; the system clock keeps running
   assign pd_enter = conv_end && !start_s;
   assign pd_exit  = start_rise;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         power_down <= 1'b0;
      end else if (conv_end) begin
         power_down <= pd_enter;
      end else if (pd_exit) begin
         power_down <= 1'b0;
      end
   end

   // Compare only a finished channel 0 conversion
   assign code_top = adc_code[adcsc_pkg::CMP_LSB +: adcsc_pkg::LIMIT_W];
   assign ot_set   = conv_end && conv_temp && code_top > overtemp_limit_reg;
   assign ot_clr = rd_rise;

   // Set wins over a release in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         overtemp_flag_n <= 1'b1;
      end else if (ot_set) begin
         overtemp_flag_n <= 1'b0;
      end else if (ot_clr) begin
         overtemp_flag_n <= 1'b1;
      end
   end

   // Output drive; release on the first of the two events
   // Synchroniser delay adds about two clocks to pin timing
   // Chip select high alone also releases, should an edge be missed
   assign out_release = rd_fall || cs_rise || cs_s;
   assign out_drive   = rd_rise;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_out_en <= 1'b0;
      end else if (out_release) begin
         data_out_en <= 1'b0;
      end else if (out_drive) begin
         data_out_en <= 1'b1;
      end
   end

endmodule

/* dv/adcsc_asserts.sv */
/* Checker for the conversion and serial control top.
   Bound to adcsc_top; sees its ports only. */
`timescale 1ns/1ps
module adcsc_asserts #(
   parameter int CONV_VOLT_CYCLES = adcsc_pkg::CONV_VOLT_CYCLES,
   parameter int CONV_TEMP_CYCLES = adcsc_pkg::CONV_TEMP_CYCLES
) (
   input wire logic                         clk,
   input wire logic                         rst_n,
   input wire logic                         convert_start_n,
   input wire logic                         chip_select_n,
   input wire logic                         rd_wr,
   input wire logic                         data_out_en,
   input wire logic                         busy,
   input wire logic                         hold,
   input wire logic                         power_down,
   input wire logic                         overtemp_flag_n,
   input wire logic [adcsc_pkg::CHAN_W-1:0] channel_sel
);
   int   cnt;
   logic is_temp;
   // Channel latched at start; writes are kept out of conversions
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt     <= 0;
         is_temp <= 1'b0;
      end else begin
         cnt <= busy ? cnt + 1 : 0;
         if (busy && cnt == 0) is_temp <= (channel_sel == adcsc_pkg::CHAN_TEMP);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_start; $fell(convert_start_n) && !busy; endsequence
   sequence s_read; $rose(rd_wr) && !chip_select_n && !busy; endsequence
   sequence s_drop; $fell(rd_wr) || $rose(chip_select_n); endsequence
   sequence s_end; $fell(busy); endsequence
   a_start_busy: assert property (s_start |-> ##[2:5] busy)
      else $error("busy missing after start");
   a_busy_cause: assert property ($rose(busy) |-> !$past(convert_start_n, 2))
      else $error("busy without start");
   a_hold_busy: assert property (hold == busy)
      else $error("hold differs from busy");
   a_volt_len: assert property (s_end and !is_temp |-> cnt == CONV_VOLT_CYCLES)
      else $error("voltage conversion length");
   a_temp_len: assert property (s_end and is_temp |-> cnt == CONV_TEMP_CYCLES)
      else $error("temperature conversion length");
   a_pdown_set: assert property (s_end and !convert_start_n && !$past(convert_start_n, 4) |-> ##[0:1] power_down)
      else $error("no power down");
   a_pdown_none: assert property (s_end and convert_start_n && $past(convert_start_n, 4) |-> ##[0:1] !power_down)
      else $error("power down with start high");
   a_flag_ch0: assert property ($fell(overtemp_flag_n) |-> is_temp && ($past(busy) || $past(busy, 2)))
      else $error("flag set without channel 0 result");
   a_read_release: assert property (s_read |-> ##[2:6] (data_out_en && overtemp_flag_n))
      else $error("read did not drive or release flag");
   a_out_float: assert property (s_drop |-> ##[0:6] !data_out_en)
      else $error("output still driven");
   a_cs_quiet: assert property (chip_select_n [*7] |-> !data_out_en)
      else $error("driven while deselected");
endmodule
bind adcsc_top adcsc_asserts #(.CONV_VOLT_CYCLES(CONV_VOLT_CYCLES), .CONV_TEMP_CYCLES(CONV_TEMP_CYCLES))
   adcsc_asserts_i (.clk(clk), .rst_n(rst_n), .convert_start_n(convert_start_n), .chip_select_n(chip_select_n),
   .rd_wr(rd_wr), .data_out_en(data_out_en), .busy(busy), .hold(hold), .power_down(power_down),
   .overtemp_flag_n(overtemp_flag_n), .channel_sel(channel_sel));

/* dv/adcsc_host.sv */
/* Host model of the serial port, 30 ns serial clock.
   Called from the bench; clock idles high between frames. */
`timescale 1ns/1ps
module adcsc_host (
   output logic      sclk,
   output logic      chip_select_n,
   output logic      rd_wr,
   output logic      data_in,
   input  wire logic data_out
);
   localparam time HALF = 15;
   initial begin
      sclk          = 1'b1;
      chip_select_n = 1'b1;
      rd_wr         = 1'b0;
      data_in       = 1'b0;
   end
   task automatic open_frame;
      chip_select_n = 1'b0;
      rd_wr         = 1'b0;
      #HALF;
   endtask
   // Released line shows the inverse, not a stale bit
   task automatic close_frame;
      #HALF;
      chip_select_n = 1'b1;
      data_in       = ~data_in;
      #100;
   endtask
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sclk    = 1'b0;
         data_in = b[i];
         #HALF;
         sclk = 1'b1;
         #HALF;
      end
      #30;
   endtask
   task automatic read_word(output logic [9:0] w);
      rd_wr = 1'b1;
      #40;
      for (int i = 9; i >= 0; i--) begin
         sclk = 1'b0;
         #HALF;
         sclk = 1'b1;
         w[i] = data_out;
         #HALF;
      end
      rd_wr = 1'b0;
      #40;
   endtask
endmodule

/* dv/adcsc_top_bench.sv */
/* Self-checking bench for adcsc_top with shortened conversions.
   Host model drives the serial port; bench drives start and code. */
`timescale 1ns/1ps
module adcsc_top_bench;
   localparam int NV = 20;
   localparam int NT = 40;
   logic       clk, rst_n, convert_start_n, sclk, chip_select_n, rd_wr, data_in;
   logic       data_out, data_out_en, busy, hold, power_down, overtemp_flag_n;
   logic [9:0] adc_code, w;
   logic [2:0] channel_sel;
   int         failures, n_checks;
   adcsc_top #(.CONV_VOLT_CYCLES(NV), .CONV_TEMP_CYCLES(NT)) adcsc_top_i (
      .clk(clk), .rst_n(rst_n), .convert_start_n(convert_start_n), .adc_code(adc_code), .sclk(sclk),
      .chip_select_n(chip_select_n), .rd_wr(rd_wr), .data_in(data_in), .data_out(data_out),
      .data_out_en(data_out_en), .busy(busy), .hold(hold), .power_down(power_down),
      .overtemp_flag_n(overtemp_flag_n), .channel_sel(channel_sel));
   adcsc_host adcsc_host_i (.sclk(sclk), .chip_select_n(chip_select_n), .rd_wr(rd_wr),
      .data_in(data_in), .data_out(data_out));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] b);
      adcsc_host_i.open_frame;
      adcsc_host_i.send_byte(b);
      adcsc_host_i.close_frame;
   endtask
   // One start pulse; busy length counted in clk cycles
   task automatic do_conv(input logic stay_low, input int n_exp);
      int n;
      n = 0;
      @(posedge clk) convert_start_n <= 1'b0;
      for (int i = 0; i < 10 && busy !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      while (busy === 1'b1 && n < 100) begin
         check(hold, 1'b1);
         @(posedge clk);
         if (n == 1 && !stay_low) convert_start_n <= 1'b1;
         #1;
         n++;
      end
      check(n[15:0], n_exp[15:0]);
      check(hold, 1'b0);
      @(posedge clk);
      #1;
      check(power_down, stay_low);
      if (stay_low) begin
         @(posedge clk) convert_start_n <= 1'b1;
         repeat (8) @(posedge clk);
         #1;
         check(power_down, 1'b0);
      end
   endtask
   task automatic t_reset;
      check({busy, hold, power_down, overtemp_flag_n, data_out_en}, 5'h02);
      check(channel_sel, 3'h0);
      $display("test reset done");
   endtask
   task automatic t_temp;
      adcsc_host_i.open_frame;
      adcsc_host_i.send_byte(8'h07);
      adcsc_host_i.send_byte(8'h80);
      adcsc_host_i.close_frame;
      wr(8'h00);
      @(posedge clk) adc_code <= 10'h200;
      do_conv(1'b0, NT);
      check(overtemp_flag_n, 1'b1);
      @(posedge clk) adc_code <= 10'h204;
      do_conv(1'b0, NT);
      check(overtemp_flag_n, 1'b0);
      $display("test temp done");
   endtask
   // Flag released first, so a voltage result above the limit could wrongly set it
   task automatic t_volt;
      wr(8'h04);
      check(channel_sel, 3'h4);
      wr(8'h05);
      adcsc_host_i.send_byte(8'h01);
      check(channel_sel, 3'h4);
      adcsc_host_i.open_frame;
      adcsc_host_i.read_word(w);
      check(w, 10'h204);
      check(overtemp_flag_n, 1'b1);
      adcsc_host_i.close_frame;
      @(posedge clk) adc_code <= 10'h2e5;
      do_conv(1'b0, NV);
      check(overtemp_flag_n, 1'b1);
      adcsc_host_i.open_frame;
      fork
         adcsc_host_i.read_word(w);
         begin
            #60;
            check(data_out_en, 1'b1);
         end
      join
      check(w, 10'h2e5);
      check(data_out_en, 1'b0);
      adcsc_host_i.close_frame;
      $display("test volt done");
   endtask
   task automatic t_pdown;
      do_conv(1'b1, NV);
      $display("test pdown done");
   endtask
   initial begin
      failures        = 0;
      n_checks        = 0;
      rst_n           = 1'b0;
      convert_start_n = 1'b1;
      adc_code        = 10'h000;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      t_reset;
      t_temp;
      t_volt;
      t_pdown;
      end_of_test;
   end
   // Whole run is a few microseconds
   initial begin
      #100000;
      failures++;
      end_of_test;
   end
endmodule
